// file: design/fsw_regs.svh
// Register layout, reset values and opcode codes of the write-enable controller
`ifndef FSW_REGS_SVH
`define FSW_REGS_SVH

`define FSW_STAT_RESET     8'h00
`define FSW_STAT_LATCH_BIT 1
`define FSW_STAT_PSLO_BIT  2
`define FSW_STAT_PSHI_BIT  3
`define FSW_OP_ADDR8_BIT   3

`define FSW_OP_WRITE_LO    8'h02
`define FSW_OP_WRITE_HI    8'h0A
`define FSW_OP_READ_LO     8'h03
`define FSW_OP_READ_HI     8'h0B
`define FSW_OP_SET_WE      8'h06
`define FSW_OP_CLR_WE      8'h04
`define FSW_OP_STAT_RD     8'h05
`define FSW_OP_STAT_WR     8'h01

`define FSW_ADDR_RESET     9'h000
`define FSW_BYTE_LAST      3'h7

`endif

// file: design/fsw_pkg.sv
// Types shared by the write-enable controller
package fsw_pkg;

   // Frame phase, Gray along opcode, address, data
   typedef enum logic [2:0] {
      FSW_OPCODE = 3'h0,
      FSW_ADDR   = 3'h1,
      FSW_DATA   = 3'h3,
      FSW_SRDATA = 3'h2,
      FSW_STATRD = 3'h6,
      FSW_IGNORE = 3'h7
   } fsw_state_t;

   typedef enum logic [2:0] {
      FSW_CMD_NONE   = 3'h0,
      FSW_CMD_SETWE  = 3'h1,
      FSW_CMD_CLRWE  = 3'h2,
      FSW_CMD_STATRD = 3'h3,
      FSW_CMD_STATWR = 3'h4,
      FSW_CMD_WRITE  = 3'h5,
      FSW_CMD_READ   = 3'h6
   } fsw_cmd_t;

endpackage

// file: design/fsw_ctrl.sv
// Serial command decoder, write-enable latch and status register
`timescale 1ns/1ps
`default_nettype none
`include "fsw_regs.svh"

// Behaviour
// - set-write-enable command sets the latch, shown as a status flag.
// - memory and status writes take effect only while the latch is one.
// - status register writes never load the latch from the written data.
// - completing a status write or lower memory write clears the latch.
// - memory write with opcode 0x0A leaves the latch set after completion.
// - nine address bits; top bit from opcode bit 3, low byte follows.
// - memory write opcodes are 0x02 lower half and 0x0A upper half.
// - memory read opcodes are 0x03 lower half and 0x0B upper half.
// - status bit 0 and bits 4 to 7 ignore writes, read zero.
// - latch sits in status bit 1 and resets to zero.
// - status bits 2 and 3 hold block-protect selects, resetting zero.
// - clear-write-enable command clears the latch, blocking all writes.
module fsw_ctrl
   import fsw_pkg::*;
(
   // System clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Serial link, mode 0
   input  wire logic       sck,
   input  wire logic       csn,
   input  wire logic       mosi,
   output logic            miso,
   output logic            misoOe,
   // Array write port
   output logic            memWrStb,
   output logic [8:0]      memWrAddr,
   output logic [7:0]      memWrData,
   // Array read port
   output logic [8:0]      memRdAddr,
   input  wire logic [7:0] memRdData,
   // Status view
   output logic [7:0]      deviceStatus
);

   // Opcode classes
   function automatic fsw_cmd_t decodeCmd(input logic [7:0] op);
      fsw_cmd_t c;
      c = FSW_CMD_NONE;
      unique case (op)
         `FSW_OP_SET_WE:  c = FSW_CMD_SETWE;
         `FSW_OP_CLR_WE:  c = FSW_CMD_CLRWE;
         `FSW_OP_STAT_RD: c = FSW_CMD_STATRD;
         `FSW_OP_STAT_WR: c = FSW_CMD_STATWR;
         `FSW_OP_WRITE_LO,
         `FSW_OP_WRITE_HI: c = FSW_CMD_WRITE;
         `FSW_OP_READ_LO,
         `FSW_OP_READ_HI: c = FSW_CMD_READ;
         default:         c = FSW_CMD_NONE;
      endcase
      return c;
   endfunction

   // Link side: frame state, reset by select going high
   logic       linkRstN;
   logic [2:0] bitCnt_r;
   logic [6:0] shift_r;
   fsw_state_t state_r;
   logic [8:0] addr_r;
   logic       isRead_r;
   logic [7:0] rxByte;
   logic       byteDone;
   fsw_cmd_t   rxCmd;

   assign linkRstN = resetn & ~csn;
   assign rxByte   = {shift_r, mosi};
   assign byteDone = (bitCnt_r == `FSW_BYTE_LAST);
   assign rxCmd    = decodeCmd(rxByte);

   always_ff @(posedge sck or negedge linkRstN) begin
      if (!linkRstN) begin
         bitCnt_r <= 3'h0;
         shift_r  <= 7'h00;
      end else begin
         bitCnt_r <= bitCnt_r + 3'h1;
         shift_r  <= rxByte[6:0];
      end
   end

   always_ff @(posedge sck or negedge linkRstN) begin
      if (!linkRstN) begin
         state_r <= FSW_OPCODE;
      end else if (byteDone) begin
         unique case (state_r)
            FSW_OPCODE: begin
               if (rxCmd == FSW_CMD_STATRD) begin
                  state_r <= FSW_STATRD;
               end else if (rxCmd == FSW_CMD_STATWR) begin
                  state_r <= FSW_SRDATA;
               end else if (rxCmd == FSW_CMD_WRITE || rxCmd == FSW_CMD_READ) begin
                  state_r <= FSW_ADDR;
               end else begin
                  state_r <= FSW_IGNORE;
               end
            end
            FSW_ADDR:   state_r <= FSW_DATA;
            FSW_SRDATA: state_r <= FSW_IGNORE;
            FSW_DATA:   state_r <= FSW_DATA;
            FSW_STATRD: state_r <= FSW_STATRD;
            FSW_IGNORE: state_r <= FSW_IGNORE;
            default:    state_r <= FSW_IGNORE;
         endcase
      end
   end

   always_ff @(posedge sck or negedge linkRstN) begin
      if (!linkRstN) begin
         addr_r   <= `FSW_ADDR_RESET;
         isRead_r <= 1'b0;
      end else if (byteDone) begin
         if (state_r == FSW_OPCODE) begin
            addr_r[8] <= rxByte[`FSW_OP_ADDR8_BIT];
            isRead_r  <= (rxCmd == FSW_CMD_READ);
         end else if (state_r == FSW_ADDR) begin
            addr_r[7:0] <= rxByte;
         end else if (state_r == FSW_DATA) begin
            // Wraps across the whole array
            addr_r <= addr_r + 9'h001;
         end
      end
   end

   // Link-to-system events as toggles; held across frames, so reset only by resetn
   logic [4:0] togLink_r;
   logic       frameHi_r;
   logic [8:0] wrAddrL_r;
   logic [7:0] wrDataL_r;
   logic [7:0] srDataL_r;

   always_ff @(posedge sck or negedge resetn) begin
      if (!resetn) begin
         togLink_r <= 5'h00;
         frameHi_r <= 1'b0;
         wrAddrL_r <= `FSW_ADDR_RESET;
         wrDataL_r <= 8'h00;
         srDataL_r <= 8'h00;
      end else if (byteDone) begin
         if (state_r == FSW_OPCODE) begin
            if (rxCmd == FSW_CMD_SETWE) begin
               togLink_r[0] <= ~togLink_r[0];
            end
            if (rxCmd == FSW_CMD_CLRWE) begin
               togLink_r[1] <= ~togLink_r[1];
            end
            if (rxCmd == FSW_CMD_WRITE) begin
               togLink_r[4] <= ~togLink_r[4];
               frameHi_r    <= (rxByte == `FSW_OP_WRITE_HI);
            end
            if (rxCmd == FSW_CMD_STATWR) begin
               togLink_r[4] <= ~togLink_r[4];
               frameHi_r    <= 1'b0;
            end
         end else if (state_r == FSW_DATA && !isRead_r) begin
            wrAddrL_r    <= addr_r;
            wrDataL_r    <= rxByte;
            togLink_r[3] <= ~togLink_r[3];
         end else if (state_r == FSW_SRDATA) begin
            srDataL_r    <= rxByte;
            togLink_r[2] <= ~togLink_r[2];
         end
      end
   end

   // Status and read data into the link domain; status settles between frames, read data follows the address within a frame
   logic [7:0] statS1_r;
   logic [7:0] statS2_r;
   logic [7:0] rdS1_r;
   logic [7:0] rdS2_r;

   always_ff @(posedge sck or negedge resetn) begin
      if (!resetn) begin
         statS1_r <= `FSW_STAT_RESET;
         statS2_r <= `FSW_STAT_RESET;
         rdS1_r   <= 8'h00;
         rdS2_r   <= 8'h00;
      end else begin
         statS1_r <= deviceStatus;
         statS2_r <= statS1_r;
         rdS1_r   <= memRdData;
         rdS2_r   <= rdS1_r;
      end
   end

   // Shift out on the falling edge, most significant bit first
   always_ff @(negedge sck or negedge linkRstN) begin
      if (!linkRstN) begin
         miso <= 1'b0;
      end else if (state_r == FSW_STATRD) begin
         miso <= statS2_r[~bitCnt_r];
      end else if (state_r == FSW_DATA && isRead_r) begin
         miso <= rdS2_r[~bitCnt_r];
      end else begin
         miso <= 1'b0;
      end
   end

   assign misoOe = (state_r == FSW_STATRD) || (state_r == FSW_DATA && isRead_r);

   // System side: event and select synchronisers
   logic [4:0] togS1_r;
   logic [4:0] togS2_r;
   logic [4:0] togS3_r;
   logic [4:0] evPulse;

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_evsync
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               togS1_r[gi] <= 1'b0;
               togS2_r[gi] <= 1'b0;
               togS3_r[gi] <= 1'b0;
            end else begin
               togS1_r[gi] <= togLink_r[gi];
               togS2_r[gi] <= togS1_r[gi];
               togS3_r[gi] <= togS2_r[gi];
            end
         end
         assign evPulse[gi] = togS2_r[gi] ^ togS3_r[gi];
      end
   endgenerate

   logic evSetWe;
   logic evClrWe;
   logic evStatWr;
   logic evByte;
   logic evFrame;
   assign evSetWe  = evPulse[0];
   assign evClrWe  = evPulse[1];
   assign evStatWr = evPulse[2];
   assign evByte   = evPulse[3];
   assign evFrame  = evPulse[4];

   logic csnS1_r;
   logic csnS2_r;
   logic csnS3_r;
   logic frameEnd;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         csnS1_r <= 1'b1;
         csnS2_r <= 1'b1;
         csnS3_r <= 1'b1;
      end else begin
         csnS1_r <= csn;
         csnS2_r <= csnS1_r;
         csnS3_r <= csnS2_r;
      end
   end
   assign frameEnd = csnS2_r & ~csnS3_r;

   // Pending latch clear for the frame in progress
   logic pendClear_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pendClear_r <= 1'b0;
      end else if (evFrame) begin
         // lower writes and status writes clear at completion
         pendClear_r <= ~frameHi_r;
      end else if (frameEnd) begin
         pendClear_r <= 1'b0;
      end
   end

   // Write-enable latch; a set arriving with a clear wins
   logic wrEnLatch_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wrEnLatch_r <= 1'b0;
      end else if (evSetWe) begin
         wrEnLatch_r <= 1'b1;
      end else if (evClrWe || (frameEnd && pendClear_r)) begin
         wrEnLatch_r <= 1'b0;
      end
   end

   // Block-protect selects
   logic [1:0] protSel_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         protSel_r <= 2'b00;
      end else if (evStatWr && wrEnLatch_r) begin
         // status write only touches the selects
         protSel_r <= srDataL_r[`FSW_STAT_PSHI_BIT:`FSW_STAT_PSLO_BIT];
      end
   end

   // Array write strobe, gated by the latch
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         memWrStb  <= 1'b0;
         memWrAddr <= `FSW_ADDR_RESET;
         memWrData <= 8'h00;
      end else begin
         memWrStb <= evByte && wrEnLatch_r;
         if (evByte && wrEnLatch_r) begin
            memWrAddr <= wrAddrL_r;
            memWrData <= wrDataL_r;
         end
      end
   end

   // Read address follows the link counter; quasi-static within a byte
   logic [8:0] rdAddrS1_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdAddrS1_r <= `FSW_ADDR_RESET;
         memRdAddr  <= `FSW_ADDR_RESET;
      end else begin
         rdAddrS1_r <= addr_r;
         memRdAddr  <= rdAddrS1_r;
      end
   end

   assign deviceStatus = {4'h0, protSel_r, wrEnLatch_r, 1'b0};

   chk_setwe_sets: assert property (@(posedge clk) disable iff (!resetn)
      evSetWe |=> deviceStatus[`FSW_STAT_LATCH_BIT])
      else $error("latch not set after set command");

   chk_write_gated: assert property (@(posedge clk) disable iff (!resetn)
      (evByte && !wrEnLatch_r) |=> !memWrStb)
      else $error("array written with latch clear");

   chk_statwr_keeps: assert property (@(posedge clk) disable iff (!resetn)
      (evStatWr && !evSetWe && !evClrWe && !frameEnd) |=> $stable(wrEnLatch_r))
      else $error("status write changed latch");

   chk_lower_clears: assert property (@(posedge clk) disable iff (!resetn)
      (frameEnd && pendClear_r && !evSetWe) |=> !wrEnLatch_r ##1 !pendClear_r)
      else $error("latch survived completed write");

   chk_upper_keeps: assert property (@(posedge clk) disable iff (!resetn)
      (frameEnd && !pendClear_r && !evSetWe && !evClrWe) |=> $stable(wrEnLatch_r))
      else $error("upper write frame changed latch");

   chk_addr_msb: assert property (@(posedge sck) disable iff (!linkRstN)
      (state_r == FSW_OPCODE && byteDone && rxCmd == FSW_CMD_WRITE)
      |=> addr_r[8] == $past(rxByte[`FSW_OP_ADDR8_BIT]))
      else $error("address top bit not from opcode");

   chk_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
      deviceStatus[0] == 1'b0 && deviceStatus[7:4] == 4'h0)
      else $error("reserved status bit set");

   chk_protect_cause: assert property (@(posedge clk) disable iff (!resetn)
      !$stable(protSel_r) |-> $past(evStatWr && wrEnLatch_r))
      else $error("protect selects changed without enabled status write");

   chk_clrwe_clears: assert property (@(posedge clk) disable iff (!resetn)
      (evClrWe && !evSetWe) |=> !wrEnLatch_r ##1 (!wrEnLatch_r || $past(evSetWe)))
      else $error("latch not cleared by clear command");

endmodule

`default_nettype wire

// file: tb/fsw_host_model.sv
// Host controller model driving the serial link in mode 0
`timescale 1ns/1ps
`default_nettype none
module fsw_host_model (
   // Serial link
   output logic      sck,
   output logic      csn,
   output logic      mosi,
   input  wire logic miso
);
   logic [7:0] rxByte;

   initial begin
      sck    = 1'b0;
      csn    = 1'b1;
      mosi   = 1'b0;
      rxByte = 8'h00;
   end

   // opcode first, MSB first
   // Clock stands low outside frames, 12 ns period inside
   task automatic frame(input logic [7:0] tx [$]);
      csn = 1'b0;
      #6;
      foreach (tx[i]) begin
         for (int b = 7; b >= 0; b--) begin
            mosi = tx[i][b];
            #6;
            sck    = 1'b1;
            rxByte = {rxByte[6:0], miso};
            #6;
            sck = 1'b0;
         end
      end
      #12;
      csn  = 1'b1;
      // Released line shows the inverse so no stale bit looks valid
      mosi = ~mosi;
      #120;
   endtask
endmodule
`default_nettype wire

// file: tb/test_fsw_ctrl.sv
// Self-checking bench of the write-enable controller
`timescale 1ns/1ps
`default_nettype none
module test_fsw_ctrl;
   import fsw_pkg::*;

   logic        clk;
   logic        resetn;
   wire logic   sck;
   wire logic   csn;
   wire logic   mosi;
   logic        miso;
   logic        misoOe;
   logic        memWrStb;
   logic [8:0]  memWrAddr;
   logic [7:0]  memWrData;
   logic [8:0]  memRdAddr;
   logic [7:0]  memRdData = 8'h00;
   logic [8:0]  rdAddrSeen = 9'h000;
   logic [7:0]  deviceStatus;
   logic [7:0]  mem [512];
   logic [16:0] wrLog [$];
   int          nMismatch;
   int          nTests;

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   fsw_ctrl i_dut (
      .clk          (clk),
      .resetn       (resetn),
      .sck          (sck),
      .csn          (csn),
      .mosi         (mosi),
      .miso         (miso),
      .misoOe       (misoOe),
      .memWrStb     (memWrStb),
      .memWrAddr    (memWrAddr),
      .memWrData    (memWrData),
      .memRdAddr    (memRdAddr),
      .memRdData    (memRdData),
      .deviceStatus (deviceStatus)
   );

   fsw_host_model i_host (
      .sck  (sck),
      .csn  (csn),
      .mosi (mosi),
      .miso (miso)
   );

   // Array stand-in, logs every strobe
   always @(posedge clk) begin
      if (memWrStb === 1'b1) begin
         mem[memWrAddr] <= memWrData;
         wrLog.push_back({memWrAddr, memWrData});
      end
      memRdData <= mem[memRdAddr];
      // Read address only stands while the frame is open
      if (misoOe === 1'b1) begin
         rdAddrSeen <= memRdAddr;
      end
   end

   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      nTests++;
      if (seen !== exp) begin
         nMismatch++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // Effects land within a few clocks of the last edge
   task automatic settle();
      repeat (10) @(posedge clk);
      #1;
   endtask

   task automatic stat(input logic [7:0] exp);
      settle();
      check({8'h00, misoOe, deviceStatus}, {9'h000, exp});
   endtask

   task automatic giveVerdict();
      $display("Comparisons %0d, mismatches %0d", nTests, nMismatch);
      if (nMismatch == 0 && nTests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #200000;
      nMismatch++;
      giveVerdict();
   end

   initial begin
      nMismatch = 0;
      nTests    = 0;
      resetn    = 1'b0;
      foreach (mem[i]) mem[i] = 8'hC3;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (5) @(posedge clk);
      stat(8'h00);
      i_host.frame('{8'h02, 8'h10, 8'hAA});
      settle();
      check(wrLog.size(), 0);
      i_host.frame('{8'h06});
      stat(8'h02);
      i_host.frame('{8'h02, 8'h34, 8'h55, 8'h66});
      settle();
      check(wrLog.size(), 2);
      check(wrLog[0], {9'h034, 8'h55});
      check(wrLog[1], {9'h035, 8'h66});
      stat(8'h00);
      wrLog.delete();
      i_host.frame('{8'h06});
      i_host.frame('{8'h0A, 8'h34, 8'h77});
      settle();
      check(wrLog[0], {9'h134, 8'h77});
      stat(8'h02);
      i_host.frame('{8'h02, 8'h40, 8'h12});
      settle();
      check(wrLog.size(), 2);
      stat(8'h00);
      i_host.frame('{8'h06});
      i_host.frame('{8'h0A, 8'hFF, 8'h01});
      i_host.frame('{8'h04});
      stat(8'h00);
      i_host.frame('{8'h06});
      i_host.frame('{8'h01, 8'hFD});
      stat(8'h0C);
      i_host.frame('{8'h01, 8'h00});
      stat(8'h0C);
      i_host.frame('{8'h05, 8'h00});
      check({9'h000, i_host.rxByte}, 17'h0000C);
      i_host.frame('{8'h06});
      stat(8'h0E);
      i_host.frame('{8'h04});
      stat(8'h0C);
      wrLog.delete();
      i_host.frame('{8'h02, 8'h00, 8'h11});
      settle();
      check(wrLog.size(), 0);
      i_host.frame('{8'h0B, 8'h77, 8'h00});
      settle();
      check({8'h00, rdAddrSeen}, 17'h00177);
      i_host.frame('{8'h03, 8'h12, 8'h00});
      settle();
      check({8'h00, rdAddrSeen}, 17'h00012);
      i_host.frame('{8'h06});
      i_host.frame('{8'h01, 8'h00});
      stat(8'h00);
      giveVerdict();
   end
endmodule
`default_nettype wire
